// [inc/sim_pkg.sv]
package sim_pkg;

  // Register map
  localparam logic [11:0] SIM_CTRL_STATUS_OFFSET = 12'h000;
  localparam int SIM_REG_W = 8;
  localparam logic [7:0] SIM_CTRL_STATUS_RESET = 8'h00;

  // Field positions of integrity_control_status
  localparam int SIM_BIT_VOLT_WARN_IRQ_EN = 6;
  localparam int SIM_BIT_VOLT_WARN_FLAG = 5;
  localparam int SIM_BIT_LOW_VOLT_RESET_FLAG = 4;
  localparam int SIM_BIT_RESERVED = 3;
  localparam int SIM_BIT_CLOCK_FAULT_IRQ_EN = 2;
  localparam int SIM_BIT_CLOCK_FAULT_FLAG = 1;
  localparam int SIM_BIT_WATCHDOG_RESET_FLAG = 0;

  // Reset delay in CPU cycles, selected by option
  localparam int SIM_RESET_DELAY_SHORT_CYC = 256;
  localparam int SIM_RESET_DELAY_LONG_CYC = 4096;
  localparam int SIM_DELAY_CNT_W = 13;

  // Clock source selection
  typedef enum logic [1:0] {
    SIM_CLK_MAIN = 2'b01,
    SIM_CLK_SAFE = 2'b10
  } sim_clk_src_e;

endpackage

// [design/sim_system_integrity.sv]
// Contract
// - With warning irq enabled, every change of the warning flag outside the reset delay raises a request.
// - Warning flag is hardware-only, 0 above rising threshold, 1 below falling.
// - A crossing inside the reset delay produces no warning interrupt.
// - Enable set before a slow rise crosses gives two interrupts.
// - Enable set after the crossing gives exactly one interrupt.
// - Pending warning indication clears on entry to its service routine.
// - Oscillator glitch filter works only while the multiplier loop is on.
// - Lost main clock switches the CPU clock to the safe oscillator.
// - Recovered main clock switches the CPU clock back automatically.
// - Fault flag set while safe clock runs; read clears it after recovery.
// - Fault flag with fault irq enable requests a clock-fault interrupt.
// - Clock security disabled forces fault flag 0 and ignores its enable.
// - Both interrupts wake from wait, never from halt.
// - Halt freezes register, stops clock security; interrupt wake resumes config.
// - Interrupts reach the CPU only when enabled and CPU mask is clear.
// - Low-voltage reset flag set by that reset, cleared by writing zero.
// - Low-voltage reset flag survives later pin or watchdog resets.
// - Watchdog flag set by watchdog reset, cleared by zero write or LV reset.
// - Flags encode cause: 00 pin, watchdog-only watchdog, LV flag low-voltage.
// - Warning function active only when low-voltage detection option is on.
`timescale 1ns/100ps
module sim_system_integrity
  import sim_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic volt_cmp_below,
  input wire logic lvd_option_en,
  input wire logic css_option_en,
  input wire logic long_reset_delay,
  input wire logic pll_en,
  input wire logic main_osc_present,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq_masked,
  input wire logic volt_warn_irq_ack,
  input wire logic lvd_reset_event,
  input wire logic wdg_reset_event,
  output logic volt_warn_irq,
  output logic clock_fault_irq,
  output logic wait_wakeup,
  output logic use_safe_osc_clock,
  output logic glitch_filter_en
);

  generate
    if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must be between 3 and 32");
    end
  endgenerate

  // The blank counter must hold the long reset delay
  generate
    if ((1 << SIM_DELAY_CNT_W) <= SIM_RESET_DELAY_LONG_CYC) begin : g_bad_delay_w
      $error("SIM_DELAY_CNT_W too narrow for the long reset delay");
    end
  endgenerate

  localparam logic [SIM_DELAY_CNT_W-1:0] DELAY_SHORT =
    SIM_DELAY_CNT_W'(SIM_RESET_DELAY_SHORT_CYC);
  localparam logic [SIM_DELAY_CNT_W-1:0] DELAY_LONG =
    SIM_DELAY_CNT_W'(SIM_RESET_DELAY_LONG_CYC);
  localparam logic [SIM_DELAY_CNT_W-1:0] DELAY_ZERO = '0;
  localparam logic [SIM_DELAY_CNT_W-1:0] DELAY_ONE = SIM_DELAY_CNT_W'(1);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_W'(SIM_CTRL_STATUS_OFFSET));
  endfunction

  // A written zero clears a software-cleared bit; a one leaves it alone
  function automatic logic zero_write(input logic [7:0] d, input int pos);
    zero_write = ~d[pos];
  endfunction

  // Reload value of the blank window, picked by the reset-delay option
  function automatic logic [SIM_DELAY_CNT_W-1:0] delay_load(input logic long_sel);
    delay_load = long_sel ? DELAY_LONG : DELAY_SHORT;
  endfunction

  // Bus decode
  logic setup_phase;
  logic access_done;
  logic wr_access;
  logic rd_access;
  logic wr_lane0;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable;
  // Writes need lane 0 since the register sits in the low byte
  assign wr_lane0 = pstrb[0];
  // Halt freezes the register, so bus writes and read side effects are dropped
  assign wr_access = access_done & pwrite & addr_hit(paddr) & wr_lane0 & ~halt_mode;
  assign rd_access = access_done & ~pwrite & addr_hit(paddr) & ~halt_mode;

  // Zero wait states: every access ends after one access cycle
  assign pready = 1'b1;
  assign pslverr = access_done & ~addr_hit(paddr);

  logic [7:0] wbyte;
  assign wbyte = pwdata[7:0];

  // Control and flag state
  logic volt_warn_irq_enable_r;
  logic clock_fault_irq_enable_r;
  logic volt_warn_flag_r;
  logic volt_warn_pending_r;
  logic clock_fault_flag_r;
  logic low_volt_reset_flag_r;
  logic watchdog_reset_flag_r;
  logic cmp_sync1_r;
  logic cmp_sync2_r;
  logic [SIM_DELAY_CNT_W-1:0] blank_cnt_r;
  logic [31:0] prdata_r;
  sim_clk_src_e clk_src_r;
  sim_clk_src_e clk_src_nxt;

  logic warn_active;
  logic css_active;
  logic warn_toggle;
  logic enable_rise;
  logic blanked;

  // Flag and pending forced low with detection off; reset flags are kept
  assign warn_active = lvd_option_en;
  // Halt stops clock security along with the safe oscillator
  assign css_active = css_option_en & ~halt_mode;
  assign blanked = (blank_cnt_r != DELAY_ZERO);

  // Two-flop synchroniser; only the second stage is looked at
  // Comparator is asynchronous, so the first stage may be metastable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_sync1_r <= 1'b0;
      cmp_sync2_r <= 1'b0;
    end else begin
      cmp_sync1_r <= volt_cmp_below;
      cmp_sync2_r <= cmp_sync1_r;
    end
  end

  // Blank window after a low-voltage reset, as long as the reset delay
  // Limitation: counted from the reset event pulse, not from the supply rise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blank_cnt_r <= DELAY_ZERO;
    end else if (lvd_reset_event) begin
      blank_cnt_r <= delay_load(long_reset_delay);
    end else if (blanked) begin
      blank_cnt_r <= blank_cnt_r - DELAY_ONE;
    end
  end

  // Flag follows the comparator; it is never written by software
  assign warn_toggle = warn_active & ~halt_mode & (cmp_sync2_r != volt_warn_flag_r);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_warn_flag_r <= 1'b0;
    end else if (!warn_active) begin
      volt_warn_flag_r <= 1'b0;
    end else if (!halt_mode) begin
      volt_warn_flag_r <= cmp_sync2_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_warn_irq_enable_r <= 1'b0;
      clock_fault_irq_enable_r <= 1'b0;
    end else if (wr_access) begin
      volt_warn_irq_enable_r <= wbyte[SIM_BIT_VOLT_WARN_IRQ_EN];
      clock_fault_irq_enable_r <= wbyte[SIM_BIT_CLOCK_FAULT_IRQ_EN];
    end
  end

  assign enable_rise = wr_access & wbyte[SIM_BIT_VOLT_WARN_IRQ_EN] & ~volt_warn_irq_enable_r;

  // Pending: set by enabling (first interrupt) or by a toggle while enabled.
  // Set wins over the service-entry acknowledge in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_warn_pending_r <= 1'b0;
    end else if (!warn_active) begin
      volt_warn_pending_r <= 1'b0;
    end else if (enable_rise) begin
      volt_warn_pending_r <= 1'b1;
    end else if (warn_toggle & volt_warn_irq_enable_r & ~blanked) begin
      volt_warn_pending_r <= 1'b1;
    end else if (volt_warn_irq_ack) begin
      volt_warn_pending_r <= 1'b0;
    end else if (wr_access & zero_write(wbyte, SIM_BIT_VOLT_WARN_IRQ_EN)) begin
      volt_warn_pending_r <= 1'b0;
    end
  end

  // Clock source selection
  // Halt drops the safe clock too, so a halted part without oscillator stays stopped
  always_comb begin
    clk_src_nxt = clk_src_r;
    case (clk_src_r)
      SIM_CLK_MAIN: begin
        if (css_active & ~main_osc_present) begin
          clk_src_nxt = SIM_CLK_SAFE;
        end
      end
      SIM_CLK_SAFE: begin
        if (~css_active | main_osc_present) begin
          clk_src_nxt = SIM_CLK_MAIN;
        end
      end
      default: begin
        clk_src_nxt = SIM_CLK_MAIN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_src_r <= SIM_CLK_MAIN;
    end else begin
      clk_src_r <= clk_src_nxt;
    end
  end

  assign use_safe_osc_clock = (clk_src_r == SIM_CLK_SAFE);
  assign glitch_filter_en = pll_en & css_active;

  // Fault flag: sticky while on safe clock; a read clears it only after
  // recovery; a main clock loss in the read cycle still clears it, and it sets again one cycle later.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_fault_flag_r <= 1'b0;
    end else if (!css_option_en) begin
      clock_fault_flag_r <= 1'b0;
    end else if (use_safe_osc_clock) begin
      clock_fault_flag_r <= 1'b1;
    end else if (rd_access) begin
      clock_fault_flag_r <= 1'b0;
    end
  end

  // Reset cause flags live outside the CPU reset so they survive it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_volt_reset_flag_r <= 1'b0;
    end else if (lvd_reset_event) begin
      low_volt_reset_flag_r <= 1'b1;
    end else if (wr_access & zero_write(wbyte, SIM_BIT_LOW_VOLT_RESET_FLAG)) begin
      low_volt_reset_flag_r <= 1'b0;
    end
  end

  // Watchdog and pin resets do not touch the low-voltage flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_reset_flag_r <= 1'b0;
    end else if (lvd_reset_event) begin
      watchdog_reset_flag_r <= 1'b0;
    end else if (wdg_reset_event) begin
      watchdog_reset_flag_r <= 1'b1;
    end else if (wr_access & zero_write(wbyte, SIM_BIT_WATCHDOG_RESET_FLAG)) begin
      watchdog_reset_flag_r <= 1'b0;
    end
  end

  // Read image; reserved bit and bit 7 read zero, written value ignored
  logic [7:0] status_img;
  always_comb begin
    status_img = SIM_CTRL_STATUS_RESET;
    status_img[SIM_BIT_VOLT_WARN_IRQ_EN] = volt_warn_irq_enable_r;
    status_img[SIM_BIT_VOLT_WARN_FLAG] = volt_warn_flag_r;
    status_img[SIM_BIT_LOW_VOLT_RESET_FLAG] = low_volt_reset_flag_r;
    status_img[SIM_BIT_RESERVED] = 1'b0;
    status_img[SIM_BIT_CLOCK_FAULT_IRQ_EN] = clock_fault_irq_enable_r;
    status_img[SIM_BIT_CLOCK_FAULT_FLAG] = clock_fault_flag_r & css_option_en;
    status_img[SIM_BIT_WATCHDOG_RESET_FLAG] = watchdog_reset_flag_r;
  end

  // Captured in the setup cycle so prdata comes from a flop
  // Trade-off: a flag changing in the access cycle shows on the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_phase & ~pwrite) begin
      prdata_r <= addr_hit(paddr) ? {24'h00_0000, status_img} : 32'h0000_0000;
    end
  end

  assign prdata = prdata_r;

  // Interrupt requests to the CPU
  logic warn_req;
  logic fault_req;
  assign warn_req = volt_warn_pending_r & volt_warn_irq_enable_r & warn_active;
  // Option gates the enable so a stale enable bit has no effect
  assign fault_req = clock_fault_flag_r & clock_fault_irq_enable_r & css_option_en;
  assign volt_warn_irq = warn_req & ~cpu_irq_masked;
  assign clock_fault_irq = fault_req & ~cpu_irq_masked;
  // Wake-up only from wait; halt never sees these events
  assign wait_wakeup = (warn_req | fault_req) & wait_mode & ~halt_mode;

endmodule

// [dv/sim_chk.sv]
`timescale 1ns/100ps
module sim_chk
  import sim_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic css_option_en,
  input wire logic lvd_option_en,
  input wire logic pll_en,
  input wire logic main_osc_present,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq_masked,
  input wire logic volt_warn_irq,
  input wire logic clock_fault_irq,
  input wire logic wait_wakeup,
  input wire logic use_safe_osc_clock,
  input wire logic glitch_filter_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_lost;
    css_option_en && !halt_mode && !main_osc_present;
  endsequence
  sequence s_any_irq;
    volt_warn_irq || clock_fault_irq;
  endsequence
  chk_safe_switch: assert property (s_lost |=> use_safe_osc_clock)
    else $error("safe clock not selected");
  chk_main_back: assert property (use_safe_osc_clock && main_osc_present |=> !use_safe_osc_clock)
    else $error("main clock not restored");
  chk_filter_gate: assert property (!pll_en || halt_mode |-> !glitch_filter_en)
    else $error("glitch filter on without loop");
  chk_css_off: assert property (!css_option_en && !$past(css_option_en) |-> !clock_fault_irq)
    else $error("fault irq with security off");
  chk_halt_wake: assert property (halt_mode |-> !wait_wakeup)
    else $error("wake from halt");
  chk_wait_wake: assert property (wait_mode && !halt_mode ##0 s_any_irq |-> wait_wakeup)
    else $error("no wake from wait");
  chk_irq_mask: assert property (cpu_irq_masked |-> !volt_warn_irq && !clock_fault_irq)
    else $error("irq while masked");
  chk_lvd_off: assert property (!lvd_option_en |-> !volt_warn_irq)
    else $error("warning irq with detection off");
endmodule
bind sim_system_integrity sim_chk chk_u (
  .clk(clk), .arst_n(arst_n), .css_option_en(css_option_en), .lvd_option_en(lvd_option_en),
  .pll_en(pll_en), .main_osc_present(main_osc_present), .halt_mode(halt_mode),
  .wait_mode(wait_mode), .cpu_irq_masked(cpu_irq_masked), .volt_warn_irq(volt_warn_irq),
  .clock_fault_irq(clock_fault_irq), .wait_wakeup(wait_wakeup),
  .use_safe_osc_clock(use_safe_osc_clock), .glitch_filter_en(glitch_filter_en)
);

// [dv/sim_cpu_model.sv]
`timescale 1ns/100ps
module sim_cpu_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic volt_warn_irq,
  input wire logic [2:0] ack_delay,
  output logic volt_warn_irq_ack,
  output logic [7:0] irq_count
);
  logic [3:0] wait_r;
  // Ack ack_delay+1 cycles after entry; skip the cycle where pending still shows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      volt_warn_irq_ack <= 1'b0;
      wait_r <= 4'h0;
      irq_count <= 8'h00;
    end else begin
      volt_warn_irq_ack <= 1'b0;
      if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
        if (wait_r == 4'h1) begin
          volt_warn_irq_ack <= 1'b1;
          irq_count <= irq_count + 8'h01;
        end
      end else if (volt_warn_irq && !volt_warn_irq_ack) begin
        wait_r <= {1'b0, ack_delay} + 4'h1;
      end
    end
  end
endmodule

// [dv/system_integrity_monitor_bench.sv]
`timescale 1ns/100ps
module system_integrity_monitor_bench;
  import sim_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, cmp, lvd_en, css_en, lng, pll;
  logic osc, halt, wt, msk, ack, lvd_ev, wdg_ev, virq, firq, wake, safe, gfe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [2:0] dly;
  logic [7:0] irqs, w;
  logic [7:0] q[$];
  int err_count, checks, cyc, n;
  sim_system_integrity dut_u (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .volt_cmp_below(cmp), .lvd_option_en(lvd_en), .css_option_en(css_en),
    .long_reset_delay(lng), .pll_en(pll), .main_osc_present(osc), .halt_mode(halt),
    .wait_mode(wt), .cpu_irq_masked(msk), .volt_warn_irq_ack(ack), .lvd_reset_event(lvd_ev),
    .wdg_reset_event(wdg_ev), .volt_warn_irq(virq), .clock_fault_irq(firq),
    .wait_wakeup(wake), .use_safe_osc_clock(safe), .glitch_filter_en(gfe));
  sim_cpu_model cpu_u (.clk(clk), .arst_n(arst_n), .volt_warn_irq(virq), .ack_delay(dly),
    .volt_warn_irq_ack(ack), .irq_count(irqs));
  task check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'($urandom()), d};
    pstrb <= 4'hf;
    if (!wr) q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input logic lv);
    @(posedge clk);
    lvd_ev <= lv;
    wdg_ev <= !lv;
    @(posedge clk);
    lvd_ev <= 1'b0;
    wdg_ev <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    if (psel && penable && pready && !pwrite) check(prdata, {24'h0, q.pop_front()});
  // Only the one mapped word answers without an error
  always @(posedge clk)
    if (psel && penable && pready) check(pslverr, paddr != 12'h000);
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report;
    end
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb, cmp, lvd_en, css_en, lng} = '0;
    {pll, halt, wt, lvd_ev, wdg_ev, dly} = '0;
    msk = 1'b1;
    osc = 1'b1;
    void'($urandom(32'hada2));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(0, 12'h000, 8'h00, 8'h00);
    apb(1, 12'h004, 8'h44, 8'h00);
    apb(0, 12'h004, 8'h00, 8'h00);
    halt <= 1'b1;
    apb(1, 12'h000, 8'h44, 8'h00);
    halt <= 1'b0;
    apb(0, 12'h000, 8'h00, 8'h00);
    {lvd_en, css_en, pll, msk} <= 4'b1110;
    dly <= 3'($urandom_range(7));
    apb(1, 12'h000, 8'h77, 8'h00);
    apb(0, 12'h000, 8'h00, 8'h44);
    repeat (20) @(posedge clk);
    check(irqs, 8'd1);
    pulse(0);
    apb(0, 12'h000, 8'h00, 8'h45);
    pulse(1);
    apb(0, 12'h000, 8'h00, 8'h54);
    pulse(0);
    apb(0, 12'h000, 8'h00, 8'h55);
    apb(1, 12'h000, 8'h44, 8'h00);
    apb(0, 12'h000, 8'h00, 8'h44);
    cmp <= 1'b1;
    repeat (10) @(posedge clk);
    apb(0, 12'h000, 8'h00, 8'h64);
    check(irqs, 8'd1);
    repeat (300) @(posedge clk);
    n = $urandom_range(4, 1);
    for (int i = 0; i < n; i++) begin
      cmp <= ~cmp;
      repeat (20) @(posedge clk);
    end
    check(irqs, 8'(1 + n));
    msk <= 1'b1;
    cmp <= ~cmp;
    repeat (20) @(posedge clk);
    check(irqs, 8'(1 + n));
    msk <= 1'b0;
    repeat (20) @(posedge clk);
    check(irqs, 8'(2 + n));
    w = {2'b0, cmp, 5'h0};
    osc <= 1'b0;
    wt <= 1'b1;
    repeat (4) @(posedge clk);
    check(safe, 1);
    check(firq, 1);
    check(wake, 1);
    check(gfe, 1);
    apb(0, 12'h000, 8'h00, w | 8'h46);
    osc <= 1'b1;
    wt <= 1'b0;
    repeat (4) @(posedge clk);
    check(safe, 0);
    apb(0, 12'h000, 8'h00, w | 8'h46);
    apb(0, 12'h000, 8'h00, w | 8'h44);
    css_en <= 1'b0;
    osc <= 1'b0;
    repeat (4) @(posedge clk);
    check(safe, 0);
    apb(0, 12'h000, 8'h00, w | 8'h44);
    final_report;
  end
endmodule
